// ===== rtl/ssm_pkg.sv
// constants, types and register map of the safe stop monitor
// assumes a single 25 MHz clock and an AXI4-Lite master on the register side
package ssm_pkg;

    // timing
    localparam int CLK_PERIOD_NS  = 40;
    localparam int TICK_PERIOD_NS = 1_000_000;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICKS_PER_S    = 1_000_000_000 / TICK_PERIOD_NS;

    // register offsets (byte addresses)
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_RAMP     = 8'h04;
    localparam logic [7:0]  ADDR_TRIP     = 8'h08;
    localparam logic [7:0]  ADDR_STILL    = 8'h0C;
    localparam logic [7:0]  ADDR_STATUS   = 8'h10;
    localparam logic [7:0]  ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0]  ADDR_IRQ_MASK = 8'h18;

    // field positions
    localparam int CTRL_PAIR_LSB   = 0;
    localparam int CTRL_PAIR_RAMP  = 2;
    localparam int CTRL_SW_RAMP    = 3;
    localparam int RAMP_VALUE_LSB  = 0;
    localparam int RAMP_UNIT_LSB   = 16;
    localparam int STAT_STATE_LSB  = 0;
    localparam int STAT_TORQUE_OFF = 3;
    localparam int STAT_FAULT_LSB  = 8;
    localparam int IRQ_OFF         = 0;
    localparam int IRQ_FAULT       = 1;
    localparam int IRQ_RAMP        = 2;

    // reset values
    localparam logic [3:0]  CTRL_RST  = 4'h0;
    localparam logic [11:0] VALUE_RST = 12'h00A;
    localparam logic [1:0]  UNIT_RST  = 2'h0;
    localparam logic [15:0] TRIP_RST  = 16'h0032;
    localparam logic [15:0] STILL_RST = 16'h000A;
    localparam logic [2:0]  MASK_RST  = 3'h0;

    // safety input pair selection
    localparam logic [1:0] PAIR_NONE      = 2'h0;
    localparam logic [1:0] PAIR_THREE_FOUR = 2'h1;
    localparam logic [1:0] PAIR_FIVE_SIX  = 2'h2;

    // stop_ramp_unit codes and their weight in Hz/s
    localparam logic [1:0] UNIT_1   = 2'h0;
    localparam logic [1:0] UNIT_10  = 2'h1;
    localparam logic [6:0] MULT_1   = 7'h01;
    localparam logic [6:0] MULT_10  = 7'h0A;
    localparam logic [6:0] MULT_100 = 7'h64;

    localparam logic [7:0] FAULT_NONE    = 8'h00;
    localparam logic [7:0] FAULT_SAFETY  = 8'h01;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_RAMP = 3'b010,
        ST_OFF  = 3'b100
    } ssm_state_t;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } ssm_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ssm_axi_rsp_t;

    // all safety pins are active low: low requests the stop
    typedef struct packed {
        logic torque_off_n;
        logic safety_input_three_n;
        logic safety_input_four_n;
        logic safety_input_five_n;
        logic safety_input_six_n;
    } ssm_pins_t;

    localparam ssm_pins_t PINS_SAFE = '0;

    typedef struct packed {
        ssm_pins_t meta;
        ssm_pins_t sync;
    } ssm_sync_t;

    typedef struct packed {
        logic [31:0] count;
        logic        tick;
    } ssm_tick_t;

    typedef struct packed {
        ssm_state_t        st;
        logic [31:0]       lim;
        logic              run_prev;
        logic              torque_off;
        logic              power_en;
        logic              ramp_stop;
        logic [7:0]        fault;
        logic [2:0]        irq_stat;
        logic [2:0]        irq_mask;
        logic              irq;
        logic [3:0]        ctrl;
        logic [1:0]        unit;
        logic [11:0]       value;
        logic [15:0]       trip;
        logic [15:0]       still;
        logic              aw_got;
        logic [ADDR_W-1:0] awaddr;
        logic              w_got;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        ssm_axi_rsp_t      rsp;
    } ssm_regs_t;

endpackage : ssm_pkg

// ===== rtl/ssm_sync.sv
// two-stage synchroniser for the safety pins
// assumes the pins are asynchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module ssm_sync
    import ssm_pkg::*;
(
    // clock and reset
    input  wire logic      aclk,
    input  wire logic      aresetn,
    // pins and synchronised copy
    input  wire ssm_pins_t pins,
    output var  ssm_pins_t pins_s
);
    ssm_sync_t q;
    ssm_sync_t d;

    always_comb begin
        d      = q;
        d.meta = pins;
        d.sync = q.meta;
    end

    // reset holds every request active so the drive starts torque-free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{meta: PINS_SAFE, sync: PINS_SAFE};
        end else begin
            q <= d;
        end
    end

    assign pins_s = q.sync;
endmodule : ssm_sync
`default_nettype wire

// ===== rtl/ssm_tick.sv
// divider giving a one-cycle enable at the ramp update rate
// assumes clr comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module ssm_tick
    import ssm_pkg::*;
#(
    parameter int CYC = TICK_CYCLES
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // control
    input  wire logic clr,
    output var  logic tick
);
    ssm_tick_t q;
    ssm_tick_t d;

    if (CYC < 2) begin : g_chk
        $error("ssm_tick: CYC must be at least 2");
    end

    always_comb begin
        d      = q;
        d.tick = 1'b0;
        if (clr || q.count == 32'(CYC - 1)) begin
            d.count = '0;
            d.tick  = !clr;
        end else begin
            d.count = q.count + 32'h0000_0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;
endmodule : ssm_tick
`default_nettype wire

// ===== rtl/ssm_top.sv
// safe stop monitor: torque-off and supervised ramp stop with AXI4-Lite registers
// assumes stator_freq and run_cmd are produced on aclk; safety pins are asynchronous
`timescale 1ns/1ps
`default_nettype none

// Function
// RQ1: the dedicated torque-off pin always requests torque-off, never remappable.
// RQ2: a chosen safety input pair, three/four or five/six, can also request it.
// RQ3: torque-off removes motor power only; control logic keeps running.
// RQ4: torque-off acts at once, without any controlled deceleration first.
// RQ5: outside logic blocks automatic restart after torque-off is released.
// RQ6: a running ramp stop overrides everything except torque-off.
// RQ7: ramp unit selects 1, 10 or 100 Hz/s.
// RQ8: supervised rate is unit times ramp value given in tenths.
// RQ9: until standstill, speed must stay at or below the supervised limit.
// RQ10: exceeding the limit raises the safety fault code and torque-off.
// RQ11: reaching the standstill level during the ramp stop triggers torque-off.
// RQ12: the ramp stop runs to completion even if its request is withdrawn.
// RQ13: all speed checks use the measured stator frequency.
// RQ14: after a stop the motor stays off until a fresh run command edge.
// RQ15: outside logic blocks automatic restart after a category 1 stop.
// RQ16: emergency reset only permits restart, by manual action at its origin.
// RQ17: limit is start frequency minus rate times time plus trip threshold.
module ssm_top
    import ssm_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // register bus
    input  wire ssm_axi_req_t axi_req,
    output var  ssm_axi_rsp_t axi_rsp,
    // safety pins
    input  wire ssm_pins_t    safety_pins,
    // drive side
    input  wire logic         run_cmd,
    input  wire logic [15:0]  stator_freq,
    output var  logic         torque_off,
    output var  logic         power_en,
    output var  logic         ramp_stop,
    output var  logic [7:0]   fault_code,
    output var  logic         irq
);
    localparam ssm_axi_rsp_t RSP_RST = '{awready: 1'b1, wready: 1'b1,
        arready: 1'b1, default: '0};
    localparam ssm_regs_t REGS_RST = '{st: ST_OFF, torque_off: 1'b1,
        run_prev: 1'b1, ctrl: CTRL_RST, unit: UNIT_RST, value: VALUE_RST,
        trip: TRIP_RST, still: STILL_RST, irq_mask: MASK_RST,
        fault: FAULT_NONE, rsp: RSP_RST, default: '0};

    ssm_regs_t   q;
    ssm_regs_t   d;
    ssm_pins_t   pins_s;
    logic        tick;
    logic        pair_hit;
    logic        sto_req;
    logic        ramp_req;
    logic        run_edge;
    logic [31:0] rate;
    logic [31:0] freq_f;
    logic        over;
    logic        at_still;
    logic [2:0]  clr;
    logic [2:0]  ev;
    logic [31:0] wm;
    logic [31:0] wr_word;

    if (TICK_CYC < 2) begin : g_chk
        $error("ssm_top: TICK_CYC must be at least 2");
    end

    ssm_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pins    (safety_pins),
        .pins_s  (pins_s)
    );

    // divider restarts on ramp entry so the first decrement is a full period late
    ssm_tick #(.CYC(TICK_CYC)) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clr     (q.st != ST_RAMP),
        .tick    (tick)
    );

    function automatic logic [6:0] unit_mult(input logic [1:0] u);
        case (u)
            UNIT_1:  unit_mult = MULT_1;
            UNIT_10: unit_mult = MULT_10;
            default: unit_mult = MULT_100;
        endcase
    endfunction : unit_mult

    // frequency in 0.1 Hz scaled to the sub-tick resolution of the limit
    function automatic logic [31:0] fine(input logic [15:0] f);
        fine = 32'(f) * 32'(TICKS_PER_S);
    endfunction : fine

    function automatic logic known(input logic [ADDR_W-1:0] a);
        case (a)
            ADDR_CTRL, ADDR_RAMP, ADDR_TRIP, ADDR_STILL,
            ADDR_STATUS, ADDR_IRQ_STAT, ADDR_IRQ_MASK: known = 1'b1;
            default: known = 1'b0;
        endcase
    endfunction : known

    function automatic logic [31:0] rd_word(input ssm_regs_t r, input logic [ADDR_W-1:0] a);
        rd_word = '0;
        case (a)
            ADDR_CTRL:     rd_word[3:0] = r.ctrl;
            ADDR_RAMP: begin
                rd_word[RAMP_VALUE_LSB +: 12] = r.value;
                rd_word[RAMP_UNIT_LSB +: 2]   = r.unit;
            end
            ADDR_TRIP:     rd_word[15:0] = r.trip;
            ADDR_STILL:    rd_word[15:0] = r.still;
            ADDR_STATUS: begin
                rd_word[STAT_STATE_LSB +: 3] = r.st;
                rd_word[STAT_TORQUE_OFF]     = r.torque_off;
                rd_word[STAT_FAULT_LSB +: 8] = r.fault;
            end
            ADDR_IRQ_STAT: rd_word[2:0] = r.irq_stat;
            ADDR_IRQ_MASK: rd_word[2:0] = r.irq_mask;
            default:       rd_word = '0;
        endcase
    endfunction : rd_word

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction : merge

    // a pair input requests when either channel is low: one dead wire stops the drive
    always_comb begin
        case (q.ctrl[CTRL_PAIR_LSB +: 2])
            PAIR_THREE_FOUR: pair_hit = !pins_s.safety_input_three_n
                                     || !pins_s.safety_input_four_n; // [RQ2]
            PAIR_FIVE_SIX:   pair_hit = !pins_s.safety_input_five_n
                                     || !pins_s.safety_input_six_n;  // [RQ2]
            default:         pair_hit = 1'b0;
        endcase
    end

    assign sto_req  = !pins_s.torque_off_n
                   || (pair_hit && !q.ctrl[CTRL_PAIR_RAMP]);         // [RQ1] [RQ2]
    assign ramp_req = q.ctrl[CTRL_SW_RAMP] || (pair_hit && q.ctrl[CTRL_PAIR_RAMP]);
    assign run_edge = run_cmd && !q.run_prev;
    assign rate     = 32'(unit_mult(q.unit)) * 32'(q.value);         // [RQ7] [RQ8]
    assign freq_f   = fine(stator_freq);                             // [RQ13]
    assign over     = freq_f > q.lim;                                // [RQ9] [RQ17]
    assign at_still = stator_freq <= q.still;                        // [RQ11] [RQ13]
    assign wm       = q.wdata & {{8{q.wstrb[3]}}, {8{q.wstrb[2]}},
                                 {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
    assign wr_word  = merge(rd_word(q, q.awaddr), q.wdata, q.wstrb);

    always_comb begin
        d          = q;
        clr        = '0;
        d.run_prev = run_cmd;

        case (q.st)
            ST_RUN: begin
                if (sto_req) begin
                    d.st = ST_OFF;                                   // [RQ4]
                end else if (ramp_req) begin
                    d.st  = ST_RAMP;
                    d.lim = freq_f + fine(q.trip);                   // [RQ17]
                end
            end
            ST_RAMP: begin
                if (sto_req) begin
                    d.st = ST_OFF;                                   // [RQ6]
                end else if (over) begin
                    d.st    = ST_OFF;                                // [RQ10]
                    d.fault = FAULT_SAFETY;                          // [RQ10]
                end else if (at_still) begin
                    d.st = ST_OFF;                                   // [RQ11]
                end else if (tick) begin
                    d.lim = (q.lim > rate) ? q.lim - rate : '0;      // [RQ9] [RQ17]
                end
            end
            ST_OFF: begin
                if (!sto_req && !ramp_req && run_edge) begin
                    d.st    = ST_RUN;                                // [RQ14]
                    d.fault = FAULT_NONE;
                end
            end
            default: d.st = ST_OFF;
        endcase
        // withdrawing ramp_req has no path out of ST_RAMP [RQ12]

        d.torque_off = (d.st == ST_OFF) || sto_req;                  // [RQ4]
        d.power_en   = !d.torque_off;                                // [RQ3]
        d.ramp_stop  = d.st == ST_RAMP;

        // bus write: address and data in either order, answered once both are in
        if (axi_req.awvalid && q.rsp.awready) begin
            d.aw_got      = 1'b1;
            d.awaddr      = axi_req.awaddr;
            d.rsp.awready = 1'b0;
        end
        if (axi_req.wvalid && q.rsp.wready) begin
            d.w_got      = 1'b1;
            d.wdata      = axi_req.wdata;
            d.wstrb      = axi_req.wstrb;
            d.rsp.wready = 1'b0;
        end
        if (q.aw_got && q.w_got) begin
            d.aw_got     = 1'b0;
            d.w_got      = 1'b0;
            d.rsp.bvalid = 1'b1;
            d.rsp.bresp  = known(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
            case (q.awaddr)
                ADDR_CTRL:     d.ctrl = wr_word[3:0];
                ADDR_RAMP: begin
                    d.value = wr_word[11:0];
                    d.unit  = wr_word[17:16];
                end
                ADDR_TRIP:     d.trip  = wr_word[15:0];
                ADDR_STILL:    d.still = wr_word[15:0];
                ADDR_IRQ_STAT: clr = wm[2:0];
                ADDR_IRQ_MASK: d.irq_mask = wr_word[2:0];
                default:       d.ctrl = q.ctrl;
            endcase
        end
        if (q.rsp.bvalid && axi_req.bready) begin
            d.rsp.bvalid  = 1'b0;
            d.rsp.awready = 1'b1;
            d.rsp.wready  = 1'b1;
        end

        if (axi_req.arvalid && q.rsp.arready) begin
            d.rsp.arready = 1'b0;
            d.rsp.rvalid  = 1'b1;
            d.rsp.rdata   = rd_word(q, axi_req.araddr);
            d.rsp.rresp   = known(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (q.rsp.rvalid && axi_req.rready) begin
            d.rsp.rvalid  = 1'b0;
            d.rsp.arready = 1'b1;
        end

        // a new event outranks a same-cycle write-one-to-clear
        ev[IRQ_OFF]   = d.torque_off && !q.torque_off;
        ev[IRQ_FAULT] = d.fault == FAULT_SAFETY && q.fault != FAULT_SAFETY;
        ev[IRQ_RAMP]  = d.st == ST_RAMP && q.st != ST_RAMP;
        d.irq_stat    = (q.irq_stat & ~clr) | ev;
        d.irq         = |(d.irq_stat & d.irq_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= REGS_RST;
        end else begin
            q <= d;
        end
    end

    assign axi_rsp    = q.rsp;
    assign torque_off = q.torque_off;
    assign power_en   = q.power_en;
    assign ramp_stop  = q.ramp_stop;
    assign fault_code = q.fault;
    assign irq        = q.irq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_trip_out;
        ##1 (q.fault == FAULT_SAFETY && torque_off && !power_en);
    endsequence

    property p_pin_off;
        !pins_s.torque_off_n |=> torque_off && !power_en;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin did not force torque-off"); // [RQ1]

    property p_pair_off;
        (q.ctrl[1:0] == PAIR_FIVE_SIX && !q.ctrl[CTRL_PAIR_RAMP]
            && !pins_s.safety_input_six_n) |=> torque_off;
    endproperty
    a_pair_off: assert property (p_pair_off) else $error("pair did not force torque-off"); // [RQ2]

    property p_power_cut;
        torque_off |-> !power_en && q.st != ST_RUN || sto_req;
    endproperty
    a_power_cut: assert property (p_power_cut) else $error("power on during torque-off"); // [RQ3]

    property p_ramp_hold;
        (q.st == ST_RAMP && !sto_req && !over && !at_still) |=> q.st == ST_RAMP;
    endproperty
    a_ramp_hold: assert property (p_ramp_hold) else $error("ramp stop left early"); // [RQ12]

    property p_ramp_prio;
        (q.st == ST_RAMP && sto_req) |=> q.st == ST_OFF ##0 torque_off;
    endproperty
    a_ramp_prio: assert property (p_ramp_prio) else $error("torque-off lost to ramp"); // [RQ6]

    property p_exceed;
        (q.st == ST_RAMP && !sto_req && over) |-> s_trip_out;
    endproperty
    a_exceed: assert property (p_exceed) else $error("overspeed not tripped"); // [RQ10]

    property p_still;
        (q.st == ST_RAMP && !sto_req && !over && at_still) |=>
            q.st == ST_OFF && torque_off && fault_code == FAULT_NONE;
    endproperty
    a_still: assert property (p_still) else $error("standstill not handled"); // [RQ11]

    property p_lim_step;
        (q.st == ST_RAMP && tick && !sto_req && !over && !at_still && q.lim > rate)
            |=> q.lim == $past(q.lim) - $past(rate);
    endproperty
    a_lim_step: assert property (p_lim_step) else $error("limit step wrong"); // [RQ17]

    property p_fresh_run;
        (q.st == ST_OFF && !run_edge) |=> q.st == ST_OFF;
    endproperty
    a_fresh_run: assert property (p_fresh_run) else $error("restart without run edge"); // [RQ14]
endmodule : ssm_top
`default_nettype wire

// ===== testbench/ssm_motor_model.sv
// behavioural motor and power stage seen through the measured stator frequency
// assumes the bench sets the commanded speed and the deceleration per cycle
`timescale 1ns/1ps
`default_nettype none
module ssm_motor_model (
    // clock
    input  wire logic        aclk,
    // drive side
    input  wire logic        power_en,
    input  wire logic        ramp_stop,
    // bench control
    input  wire logic [15:0] set_freq,
    input  wire logic [15:0] decel,
    // measurement
    output var  logic [15:0] stator_freq
);
    initial stator_freq = 16'h0000;
    // no torque: the shaft coasts, it is never braked by the drive
    always @(posedge aclk) begin
        if (!power_en) begin
            stator_freq <= (stator_freq > 16'h0014) ? stator_freq - 16'h0014 : 16'h0000;
        end else if (ramp_stop) begin
            stator_freq <= (stator_freq > decel) ? stator_freq - decel : 16'h0000;
        end else begin
            stator_freq <= set_freq;
        end
    end
endmodule : ssm_motor_model
`default_nettype wire

// ===== testbench/ssm_top_tb.sv
// self-checking bench: registers, torque-off requests and supervised ramp stop
// assumes ssm_pkg and the motor model are compiled first
`timescale 1ns/1ps
`default_nettype none
module ssm_top_tb
    import ssm_pkg::*;
;
    localparam int TCYC = 8;
    logic         aclk, aresetn, run_cmd;
    ssm_axi_req_t axi_req;
    ssm_axi_rsp_t axi_rsp;
    ssm_pins_t    pins;
    logic [15:0]  freq, set_freq, decel;
    logic         torque_off, power_en, ramp_stop, irq;
    logic [7:0]   fault_code;
    logic [31:0]  rdat;
    logic [1:0]   rrsp;
    logic [1:0]   wrsp;
    int           error_cnt = 0;
    int           comparisons = 0;
    int           n, k;
    int           mult [4] = '{1, 10, 100, 100};
    int           pidx [3] = '{4, 2, 0};

    ssm_top #(.TICK_CYC(TCYC)) uut (
        .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .safety_pins(pins), .run_cmd(run_cmd), .stator_freq(freq),
        .torque_off(torque_off), .power_en(power_en), .ramp_stop(ramp_stop),
        .fault_code(fault_code), .irq(irq));
    ssm_motor_model motor (.aclk(aclk), .power_en(power_en), .ramp_stop(ramp_stop),
        .set_freq(set_freq), .decel(decel), .stator_freq(freq));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic stop_test();
        if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic give_up();
        error_cnt++;
        $display("[ERR] %0t wait timed out", $time);
        stop_test();
    endtask : give_up

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge aclk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr  <= a;
        axi_req.wvalid  <= 1'b1;
        axi_req.wdata   <= d;
        axi_req.wstrb   <= 4'hF;
        axi_req.bready  <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
            if (t > 50) give_up();
        end while (!axi_rsp.bvalid);
        wrsp = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int t;
        t = 0;
        @(posedge aclk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr  <= a;
        axi_req.rready  <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
            if (t > 50) give_up();
        end while (!axi_rsp.rvalid);
        rdat = axi_rsp.rdata;
        rrsp = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask : rd

    // sel 0 torque_off, 1 ramp_stop, 2 fault raised; n counts the edges waited
    task automatic wait_bit(input int sel, input int lim);
        n = 0;
        while (!(sel == 0 ? torque_off === 1'b1 :
                 sel == 1 ? ramp_stop === 1'b1 : fault_code !== 8'h00)) begin
            @(posedge aclk);
            #1;
            n++;
            if (n > lim) give_up();
        end
    endtask : wait_bit

    // only a fresh run edge may restart; a held level never does
    task automatic restart();
        @(posedge aclk);
        run_cmd <= 1'b0;
        @(posedge aclk);
        run_cmd <= 1'b1;
        repeat (3) @(posedge aclk);
        #1;
    endtask : restart

    initial begin
        aresetn  = 1'b0;
        run_cmd  = 1'b1;
        axi_req  = '0;
        pins     = '1;
        set_freq = 16'h03E8;
        decel    = 16'h0000;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        #1;
        chk(power_en, 1'b0);
        rd(ADDR_RAMP);
        chk(rdat, 32'h0000_000A);
        rd(ADDR_TRIP);
        chk(rdat, 32'h0000_0032);
        rd(8'h1C);
        chk(rrsp, RESP_SLVERR);
        chk(rdat, 32'h0000_0000);
        wr(8'h1C, 32'hFFFF_FFFF);
        chk(wrsp, RESP_SLVERR);
        wr(ADDR_STATUS, 32'h0000_0000);
        chk(wrsp, RESP_OKAY);
        restart();
        chk(power_en, 1'b1);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTRL, 32'(i));
            @(posedge aclk);
            pins[pidx[i]] <= 1'b0;
            wait_bit(0, 4);
            chk(power_en, 1'b0);
            @(posedge aclk);
            pins <= '1;
            restart();
            chk(power_en, 1'b1);
        end
        wr(ADDR_IRQ_MASK, 32'h0000_0007);
        chk(wrsp, RESP_OKAY);
        wr(ADDR_IRQ_STAT, 32'h0000_0007);
        chk(irq, 1'b0);
        wr(ADDR_CTRL, 32'h0000_0008);
        wait_bit(1, 4);
        chk(irq, 1'b1);
        wr(ADDR_CTRL, 32'h0000_0000);
        repeat (2) @(posedge aclk);
        #1;
        chk(ramp_stop, 1'b1);
        @(posedge aclk);
        decel <= 16'h000A;
        wait_bit(0, 300);
        chk(fault_code, FAULT_NONE);
        rd(ADDR_STATUS);
        chk(rdat, 32'h0000_000C);
        rd(ADDR_IRQ_STAT);
        chk(rdat, 32'h0000_0005);
        wr(ADDR_IRQ_STAT, 32'h0000_0007);
        decel <= 16'h0000;
        repeat (2) @(posedge aclk);
        #1;
        chk(irq, 1'b0);
        restart();
        wr(ADDR_CTRL, 32'h0000_0005);
        pins.safety_input_three_n <= 1'b0;
        wait_bit(1, 6);
        @(posedge aclk);
        pins.torque_off_n <= 1'b0;
        wait_bit(0, 4);
        chk(ramp_stop, 1'b0);
        wr(ADDR_CTRL, 32'h0000_0000);
        pins <= '1;
        restart();
        wr(ADDR_TRIP, 32'h0000_0004);
        for (int u = 0; u < 4; u++) begin
            wr(ADDR_RAMP, (32'(u) << 16) | 32'h0000_0014);
            wr(ADDR_CTRL, 32'h0000_0008);
            wait_bit(1, 4);
            wait_bit(2, 3000);
            k = 4000 / (mult[u] * 20) + 1;
            chk(n > (k - 1) * TCYC && n <= (k + 1) * TCYC + 4, 1'b1);
            chk(fault_code, FAULT_SAFETY);
            chk(torque_off, 1'b1);
            wr(ADDR_CTRL, 32'h0000_0000);
            restart();
            chk(fault_code, FAULT_NONE);
        end
        stop_test();
    end
endmodule : ssm_top_tb
`default_nettype wire
